// ---- inc/bsc_pkg.sv ----
// Constants for the step-down converter supervisor and control block.
// Assumes a 20 MHz system clock and an AHB-Lite register bus.
`default_nettype none
package bsc_pkg;
	// ****************************************
	// Register byte offsets
	// ****************************************
	localparam logic [7:0] CTRL_OFS     = 8'h00;
	localparam logic [7:0] MASK_OFS     = 8'h04;
	localparam logic [7:0] FLAG_OFS     = 8'h08;
	localparam logic [7:0] STAT_OFS     = 8'h0C;
	localparam logic [7:0] VOUT_OFS     = 8'h10;
	localparam logic [7:0] SEQ_OFS      = 8'h1C;
	localparam logic [7:0] PMODE_OFS    = 8'h28;
	localparam logic [7:0] REG_STRIDE   = 8'h04;
	// ****************************************
	// Field positions and reset values
	// ****************************************
	localparam int         CTRL_EN_LSB  = 0;
	localparam int         CTRL_DIS_LSB = 3;
	localparam int         CTRL_DRE_BIT = 6;
	localparam int         UV_LSB       = 0;
	localparam int         OV_LSB       = 3;
	localparam int         ILIM_LSB     = 6;
	localparam int         SS_LSB       = 9;
	localparam int         ENST_LSB     = 12;
	localparam int         LPST_LSB     = 15;
	localparam int         SEQ_PART_BIT = 0;
	localparam logic [6:0] CTRL_RST     = 7'h00;
	localparam logic [5:0] MASK_RST     = 6'h00;
	localparam logic [7:0] VOUT_RST     = 8'h00;
	localparam logic [7:0] SEQ_RST      = 8'h00;
	localparam logic [5:0] PMODE_RST    = 6'h00;
	// ****************************************
	// Power mode field encodings
	// ****************************************
	localparam logic [1:0] PM_NORMAL    = 2'h0;
	localparam logic [1:0] PM_SLEEP_LP  = 2'h1;
	localparam logic [1:0] PM_FORCE_LP  = 2'h2;
	localparam logic [1:0] PM_FORCE_LP2 = 2'h3;
	// ****************************************
	// Voltage code mapping, microvolts
	// ****************************************
	localparam int         REF_W        = 22;
	localparam int         B1_BASE_UV   = 260000;
	localparam int         B1_STEP_UV   = 10000;
	localparam logic [7:0] B1_MAX_CODE  = 8'h7E;
	localparam int         B2_BASE_UV   = 600000;
	localparam int         B2_STEP_UV   = 6250;
	localparam logic [7:0] B2_MAX_CODE  = 8'hFF;
	localparam int         B3_BASE_UV   = 600000;
	localparam int         B3_STEP_UV   = 12500;
	localparam logic [7:0] B3_MAX_CODE  = 8'hFE;
	// ****************************************
	// Soft-start slope and clock
	// ****************************************
	localparam int         SLOPE_MV_US  = 17;
	localparam int         CLK_MHZ      = 20;
	localparam int         RAMP_STEP_UV = SLOPE_MV_US * 1000 / CLK_MHZ;
	// ****************************************
	// AHB-Lite codes
	// ****************************************
	localparam logic [1:0] HTRANS_NSEQ  = 2'h2;
	localparam logic       HRESP_OKAY   = 1'b0;
endpackage
`default_nettype wire

// ---- rtl/bsc_top.sv ----
// Supervisor and control logic for three step-down converters.
// Comparator inputs arrive asynchronously from the analog side; sequencer
// enables and sleep state come from logic on CLK; AHB-Lite master on CLK.
`timescale 1ns/1ps
`default_nettype none
module bsc_top (
	input  wire logic                         CLK,
	input  wire logic                         RST_N,
	input  wire logic                         HSEL,
	input  wire logic [31:0]                  HADDR,
	input  wire logic [1:0]                   HTRANS,
	input  wire logic                         HWRITE,
	input  wire logic [2:0]                   HSIZE,
	input  wire logic [31:0]                  HWDATA,
	input  wire logic                         HREADY,
	output logic      [31:0]                  HRDATA,
	output logic                              HREADYOUT,
	output logic                              HRESP,
	input  wire logic [2:0]                   UV_CMP,
	input  wire logic [2:0]                   OV_CMP,
	input  wire logic [2:0]                   ILIM_CMP,
	input  wire logic [2:0]                   SEQ_EN,
	input  wire logic                         DEVICE_SLEEP_STATE,
	output logic      [2:0]                   BUCK_EN,
	output logic      [2:0]                   BUCK_LOW_POWER,
	output logic      [2:0]                   DISCHARGE_ON,
	output logic      [bsc_pkg::REF_W-1:0]    BUCK1_REF_UV,
	output logic      [bsc_pkg::REF_W-1:0]    BUCK2_REF_UV,
	output logic      [bsc_pkg::REF_W-1:0]    BUCK3_REF_UV,
	output logic                              PWRDN_REQ
);
	localparam int RW = bsc_pkg::REF_W;

	// ****************************************
	// Comparator synchronisers
	// ****************************************
	logic [8:0] cmp_meta_q;
	logic [8:0] cmp_q;

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			cmp_meta_q <= 9'h000;
			cmp_q      <= 9'h000;
		end else begin
			cmp_meta_q <= {ILIM_CMP, OV_CMP, UV_CMP};
			cmp_q      <= cmp_meta_q;
		end
	end

	// ****************************************
	// Register state
	// ****************************************
	logic [6:0] ctrl_q;
	logic [5:0] mask_q;
	logic [5:0] flag_q;
	logic [7:0] vout_q [3];
	logic [7:0] seq_q  [3];
	logic [5:0] pmode_q;
	logic [2:0] ss_q;
	logic [2:0] en_s;
	logic [2:0] lp_s;
	logic [5:0] flag_set;
	logic [5:0] event_s;

	// ****************************************
	// AHB-Lite slave
	// ****************************************
	logic       wr_pend_q;
	logic       rd_pend_q;
	logic [7:0] addr_q;
	logic       addr_ok_q;
	logic [31:0] rdata_q;
	logic       rd_wait_q;
	logic       take;
	logic [31:0] rd_mux;

	assign take      = HSEL && HTRANS == bsc_pkg::HTRANS_NSEQ && HREADY;
	assign HREADYOUT = !(rd_pend_q && !rd_wait_q);
	assign HRESP     = bsc_pkg::HRESP_OKAY;
	assign HRDATA    = rdata_q;

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
			rd_wait_q <= 1'b0;
			addr_q    <= 8'h00;
			addr_ok_q <= 1'b0;
		end else begin
			if (rd_pend_q && !rd_wait_q) begin
				rd_wait_q <= 1'b1;
			end else begin
				wr_pend_q <= take && HWRITE;
				rd_pend_q <= take && !HWRITE;
				rd_wait_q <= 1'b0;
				addr_q    <= HADDR[7:0];
				addr_ok_q <= HADDR[31:8] == 24'h000000 && HADDR[1:0] == 2'h0;
			end
		end
	end

	// Read data taken in the wait cycle, after any earlier write landed
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (addr_ok_q) begin
			unique case (addr_q)
				bsc_pkg::CTRL_OFS:  rd_mux[6:0] = ctrl_q;
				bsc_pkg::MASK_OFS:  rd_mux[5:0] = mask_q;
				bsc_pkg::FLAG_OFS:  rd_mux[5:0] = flag_q;
				bsc_pkg::STAT_OFS:  rd_mux[17:0] = {lp_s, en_s, ss_q, cmp_q};
				bsc_pkg::VOUT_OFS:  rd_mux[7:0] = vout_q[0];
				8'h14:              rd_mux[7:0] = vout_q[1];
				8'h18:              rd_mux[7:0] = vout_q[2];
				bsc_pkg::SEQ_OFS:   rd_mux[7:0] = seq_q[0];
				8'h20:              rd_mux[7:0] = seq_q[1];
				8'h24:              rd_mux[7:0] = seq_q[2];
				bsc_pkg::PMODE_OFS: rd_mux[5:0] = pmode_q;
				default:            rd_mux = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			rdata_q <= 32'h0000_0000;
		end else if (rd_pend_q && !rd_wait_q) begin
			rdata_q <= rd_mux;
		end
	end

	logic wr_ok;
	assign wr_ok = wr_pend_q && addr_ok_q;

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			ctrl_q  <= bsc_pkg::CTRL_RST;
			mask_q  <= bsc_pkg::MASK_RST;
			pmode_q <= bsc_pkg::PMODE_RST;
		end else if (wr_ok) begin
			if (addr_q == bsc_pkg::CTRL_OFS) begin
				ctrl_q <= HWDATA[6:0];
			end
			if (addr_q == bsc_pkg::MASK_OFS) begin
				mask_q <= HWDATA[5:0];
			end
			if (addr_q == bsc_pkg::PMODE_OFS) begin
				pmode_q <= HWDATA[5:0];
			end
		end
	end

	// Write-one-to-clear; a new detection in the same cycle wins
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			flag_q <= 6'h00;
		end else begin
			flag_q <= (flag_q & ~((wr_ok && addr_q == bsc_pkg::FLAG_OFS)
				? HWDATA[5:0] : 6'h00)) | flag_set;
		end
	end

	// Power-down request pulse on any unmasked new event
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			PWRDN_REQ <= 1'b0;
		end else begin
			PWRDN_REQ <= |(event_s & ~mask_q);
		end
	end

	// ****************************************
	// Per-converter control
	// ****************************************
	logic [RW-1:0] ref_q [3];

	assign BUCK1_REF_UV = ref_q[0];
	assign BUCK2_REF_UV = ref_q[1];
	assign BUCK3_REF_UV = ref_q[2];
	assign BUCK_EN      = en_s;

	for (genvar i = 0; i < 3; i++) begin : g_ch
		localparam int         BASE = (i == 0) ? bsc_pkg::B1_BASE_UV
			: (i == 1) ? bsc_pkg::B2_BASE_UV : bsc_pkg::B3_BASE_UV;
		localparam int         STEP = (i == 0) ? bsc_pkg::B1_STEP_UV
			: (i == 1) ? bsc_pkg::B2_STEP_UV : bsc_pkg::B3_STEP_UV;
		localparam logic [7:0] MAXC = (i == 0) ? bsc_pkg::B1_MAX_CODE
			: (i == 1) ? bsc_pkg::B2_MAX_CODE : bsc_pkg::B3_MAX_CODE;
		localparam logic [RW-1:0] RSTEP = RW'(bsc_pkg::RAMP_STEP_UV);

		logic [7:0]    code_c;
		logic [RW-1:0] tgt;
		logic [RW-1:0] diff;
		logic [RW-1:0] nxt;
		logic          en_q;
		logic          rup_q;
		logic          rdn_q;
		logic          uv_blank;
		logic          ov_blank;
		logic          uv_qual;
		logic          ov_qual;
		logic          uv_prev_q;
		logic          ov_prev_q;
		logic [1:0]    pm;

		assign code_c = (vout_q[i] > MAXC) ? MAXC : vout_q[i];
		assign tgt    = RW'(BASE) + RW'(code_c) * RW'(STEP);
		assign diff   = (ref_q[i] > tgt) ? ref_q[i] - tgt : tgt - ref_q[i];
		assign nxt    = (diff > RSTEP)
			? ((ref_q[i] > tgt) ? ref_q[i] - RSTEP : ref_q[i] + RSTEP)
			: tgt;
		assign en_s[i] = ctrl_q[bsc_pkg::CTRL_EN_LSB + i]
			| (seq_q[i][bsc_pkg::SEQ_PART_BIT] & SEQ_EN[i]);
		assign pm      = pmode_q[2*i +: 2];
		assign lp_s[i] = pm == bsc_pkg::PM_FORCE_LP
			|| pm == bsc_pkg::PM_FORCE_LP2
			|| (pm == bsc_pkg::PM_SLEEP_LP && DEVICE_SLEEP_STATE);
		assign BUCK_LOW_POWER[i] = lp_s[i] && en_s[i];
		assign DISCHARGE_ON[i] = !en_s[i]
			&& !ctrl_q[bsc_pkg::CTRL_DIS_LSB + i];

		always_ff @(posedge CLK or negedge RST_N) begin
			if (!RST_N) begin
				vout_q[i] <= bsc_pkg::VOUT_RST;
				seq_q[i]  <= bsc_pkg::SEQ_RST;
			end else if (wr_ok) begin
				if (addr_q == bsc_pkg::VOUT_OFS + 8'(i) * bsc_pkg::REG_STRIDE) begin
					vout_q[i] <= (i == 0) ? {1'b0, HWDATA[6:0]} : HWDATA[7:0];
				end
				if (addr_q == bsc_pkg::SEQ_OFS + 8'(i) * bsc_pkg::REG_STRIDE) begin
					seq_q[i] <= HWDATA[7:0];
				end
			end
		end

		// Reference ramp: soft-start, buck1 controlled ramps, jumps
		always_ff @(posedge CLK or negedge RST_N) begin
			if (!RST_N) begin
				en_q     <= 1'b0;
				ss_q[i]  <= 1'b0;
				rup_q    <= 1'b0;
				rdn_q    <= 1'b0;
				ref_q[i] <= '0;
			end else begin
				en_q <= en_s[i];
				if (!en_s[i]) begin
					ss_q[i]  <= 1'b0;
					rup_q    <= 1'b0;
					rdn_q    <= 1'b0;
					ref_q[i] <= '0;
				end else if (!en_q) begin
					ss_q[i]  <= 1'b1;
					ref_q[i] <= '0;
				end else if (ss_q[i] || rup_q || rdn_q) begin
					ref_q[i] <= nxt;
					if (nxt == tgt) begin
						ss_q[i] <= 1'b0;
						rup_q   <= 1'b0;
						rdn_q   <= 1'b0;
					end
				end else if (tgt > ref_q[i]) begin
					if (i == 0) begin
						rup_q <= 1'b1;
					end else begin
						ref_q[i] <= tgt;
					end
				end else if (tgt < ref_q[i]) begin
					if (i == 0 && ctrl_q[bsc_pkg::CTRL_DRE_BIT]) begin
						rdn_q <= 1'b1;
					end else begin
						ref_q[i] <= tgt;
					end
				end
			end
		end

		assign uv_blank = ss_q[i] || rup_q;
		assign ov_blank = ss_q[i] || rdn_q;
		assign uv_qual  = cmp_q[bsc_pkg::UV_LSB + i] && !uv_blank;
		assign ov_qual  = cmp_q[bsc_pkg::OV_LSB + i] && !ov_blank;
		assign flag_set[bsc_pkg::UV_LSB + i] = uv_qual;
		assign flag_set[bsc_pkg::OV_LSB + i] = ov_qual;
		assign event_s[bsc_pkg::UV_LSB + i]  = uv_qual && !uv_prev_q;
		assign event_s[bsc_pkg::OV_LSB + i]  = ov_qual && !ov_prev_q;

		always_ff @(posedge CLK or negedge RST_N) begin
			if (!RST_N) begin
				uv_prev_q <= 1'b0;
				ov_prev_q <= 1'b0;
			end else begin
				uv_prev_q <= uv_qual;
				ov_prev_q <= ov_qual;
			end
		end
	end
endmodule
`default_nettype wire

// ---- bench/bsc_host.sv ----
// AHB-Lite single-transfer master standing in for the host processor.
// Assumes HREADY is the one slave's HREADYOUT.
`timescale 1ns/1ps
`default_nettype none
module bsc_host (
	input  wire logic        CLK,
	input  wire logic        HREADY,
	input  wire logic [31:0] HRDATA,
	output logic             HSEL,
	output logic [31:0]      HADDR,
	output logic [1:0]       HTRANS,
	output logic             HWRITE,
	output logic [2:0]       HSIZE,
	output logic [31:0]      HWDATA
);
	initial begin
		HSEL = 1'b0;
		HADDR = 32'h0;
		HTRANS = 2'h0;
		HWRITE = 1'b0;
		HSIZE = 3'h2;
		HWDATA = 32'h0;
	end
	// Ready sampled between edges, value as seen at the next edge
	task automatic xfer(input logic w, input logic [31:0] a,
		input logic [31:0] wd, output logic [31:0] rdat);
		logic r;
		@(posedge CLK);
		HSEL <= 1'b1;
		HADDR <= a;
		HTRANS <= bsc_pkg::HTRANS_NSEQ;
		HWRITE <= w;
		do begin
			@(negedge CLK);
			r = HREADY;
			@(posedge CLK);
		end while (r !== 1'b1);
		HSEL <= 1'b0;
		HTRANS <= 2'h0;
		HWDATA <= wd;
		do begin
			@(negedge CLK);
			r = HREADY;
			rdat = HRDATA;
			@(posedge CLK);
		end while (r !== 1'b1);
	endtask
endmodule
`default_nettype wire

// ---- bench/bsc_chk.sv ----
// Port-level assertions for the converter supervisor.
// Bound to bsc_top; single clock domain.
`timescale 1ns/1ps
`default_nettype none
module bsc_chk (
	input  wire logic        CLK,
	input  wire logic        RST_N,
	input  wire logic        HSEL,
	input  wire logic [1:0]  HTRANS,
	input  wire logic        HWRITE,
	input  wire logic        HREADY,
	input  wire logic        HREADYOUT,
	input  wire logic        HRESP,
	input  wire logic [2:0]  UV_CMP,
	input  wire logic [2:0]  OV_CMP,
	input  wire logic [2:0]  BUCK_EN,
	input  wire logic [2:0]  BUCK_LOW_POWER,
	input  wire logic [2:0]  DISCHARGE_ON,
	input  wire logic [21:0] BUCK1_REF_UV,
	input  wire logic [21:0] BUCK2_REF_UV,
	input  wire logic [21:0] BUCK3_REF_UV,
	input  wire logic        PWRDN_REQ
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	logic take;
	assign take = HSEL && HTRANS == 2'h2 && HREADY;
	a_hresp_okay: assert property (HRESP == 1'b0)
		else $error("response not okay");
	a_read_wait: assert property (take && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
		else $error("read wait state wrong");
	a_write_ready: assert property (take && HWRITE |=> HREADYOUT)
		else $error("write stalled");
	a_disch_off_en: assert property ((DISCHARGE_ON & BUCK_EN) == 3'h0)
		else $error("discharge while enabled");
	a_lp_only_en: assert property ((BUCK_LOW_POWER & ~BUCK_EN) == 3'h0)
		else $error("low power while off");
	a_ref_zero_off: assert property (!BUCK_EN[1] && $past(!BUCK_EN[1])
		|-> BUCK2_REF_UV == 22'h0)
		else $error("reference not zero while off");
	a_ramp_start: assert property ($rose(BUCK_EN[1])
		|-> ##2 BUCK2_REF_UV <= 22'h0006A4)
		else $error("soft-start too steep");
	a_ref_bounds: assert property (BUCK3_REF_UV <= 22'h399A18
		&& BUCK2_REF_UV <= 22'h21801E && BUCK1_REF_UV <= 22'h173180)
		else $error("reference above maximum");
	a_pwrdn_cause: assert property (PWRDN_REQ |-> ($past(UV_CMP, 3)
		| $past(OV_CMP, 3) | $past(UV_CMP, 4) | $past(OV_CMP, 4)) != 3'h0)
		else $error("power-down without comparator");
endmodule
bind bsc_top bsc_chk u_chk (.CLK(CLK), .RST_N(RST_N), .HSEL(HSEL),
	.HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY),
	.HREADYOUT(HREADYOUT), .HRESP(HRESP), .UV_CMP(UV_CMP), .OV_CMP(OV_CMP),
	.BUCK_EN(BUCK_EN), .BUCK_LOW_POWER(BUCK_LOW_POWER),
	.DISCHARGE_ON(DISCHARGE_ON), .BUCK1_REF_UV(BUCK1_REF_UV),
	.BUCK2_REF_UV(BUCK2_REF_UV), .BUCK3_REF_UV(BUCK3_REF_UV),
	.PWRDN_REQ(PWRDN_REQ));
`default_nettype wire

// ---- bench/test_buck_supervisor_control.sv ----
// Self-checking bench for the converter supervisor.
// Host model drives the bus; comparators and sequencer driven here.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
	err_total++; $display("mismatch %s exp %0h got %0h", n, e, g); end end
module test_buck_supervisor_control;
	logic CLK = 1'b0, RST_N = 1'b0, HSEL, HWRITE, HREADYOUT, HRESP, PWRDN_REQ;
	logic [31:0] HADDR, HWDATA, HRDATA, d;
	logic [1:0] HTRANS;
	logic [2:0] HSIZE, BUCK_EN, BUCK_LOW_POWER, DISCHARGE_ON;
	logic [2:0] UV_CMP = 3'h0, OV_CMP = 3'h0, ILIM_CMP = 3'h0, SEQ_EN = 3'h0;
	logic SLP = 1'b0;
	logic [21:0] REF1, REF2, REF3;
	int err_total = 0, comparisons = 0, pd = 0;
	always #25 CLK = ~CLK;
	// Counted at the falling edge, once per one-cycle pulse
	always @(negedge CLK) if (PWRDN_REQ === 1'b1) pd++;
	bsc_host host (.CLK(CLK), .HREADY(HREADYOUT), .HRDATA(HRDATA), .HSEL(HSEL),
		.HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
		.HWDATA(HWDATA));
	bsc_top DUT (.CLK(CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR),
		.HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
		.HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
		.HRESP(HRESP), .UV_CMP(UV_CMP), .OV_CMP(OV_CMP), .ILIM_CMP(ILIM_CMP),
		.SEQ_EN(SEQ_EN), .DEVICE_SLEEP_STATE(SLP), .BUCK_EN(BUCK_EN),
		.BUCK_LOW_POWER(BUCK_LOW_POWER), .DISCHARGE_ON(DISCHARGE_ON),
		.BUCK1_REF_UV(REF1), .BUCK2_REF_UV(REF2), .BUCK3_REF_UV(REF3),
		.PWRDN_REQ(PWRDN_REQ));
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		host.xfer(1'b1, {24'h0, a}, v, d);
	endtask
	task automatic rd(input logic [7:0] a);
		host.xfer(1'b0, {24'h0, a}, 32'h0, d);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge CLK);
		#1;
	endtask
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge CLK);
		err_total++;
		conclude();
	end
	initial begin
		logic [7:0] ofs [6] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h28, 8'h80};
		cyc(3);
		RST_N <= 1'b1;
		foreach (ofs[i]) begin
			rd(ofs[i]);
			`CHK("reset reg", 32'h0, d)
		end
		`CHK("disch rst", 3'h7, DISCHARGE_ON)
		$display("test reset done");
		wr(bsc_pkg::VOUT_OFS + 8'h04, 32'h20);
		wr(bsc_pkg::CTRL_OFS, 32'h2);
		cyc(2);
		`CHK("en2", 3'h2, BUCK_EN)
		`CHK("disch2", 3'h5, DISCHARGE_ON)
		UV_CMP[1] <= 1'b1;
		rd(bsc_pkg::STAT_OFS);
		cyc(6);
		`CHK("live uv", 1'b1, d[bsc_pkg::UV_LSB + 1])
		UV_CMP[1] <= 1'b0;
		rd(bsc_pkg::FLAG_OFS);
		`CHK("uv blank", 32'h0, d)
		cyc(1000);
		`CHK("ref2", 22'(bsc_pkg::B2_BASE_UV + 32 * bsc_pkg::B2_STEP_UV), REF2)
		UV_CMP[1] <= 1'b1;
		cyc(8);
		`CHK("uv pd", 1, pd)
		rd(bsc_pkg::FLAG_OFS);
		`CHK("uv flag", 32'h2, d)
		UV_CMP[1] <= 1'b0;
		wr(bsc_pkg::FLAG_OFS, 32'h2);
		wr(bsc_pkg::MASK_OFS, 32'h10);
		wr(bsc_pkg::VOUT_OFS + 8'h04, 32'hFF);
		cyc(3);
		`CHK("jump2", 22'(bsc_pkg::B2_BASE_UV + 255 * bsc_pkg::B2_STEP_UV), REF2)
		OV_CMP[1] <= 1'b1;
		cyc(8);
		`CHK("ov masked", 1, pd)
		rd(bsc_pkg::FLAG_OFS);
		`CHK("ov flag", 32'h10, d)
		OV_CMP[1] <= 1'b0;
		wr(bsc_pkg::FLAG_OFS, 32'h10);
		$display("test buck2 done");
		wr(bsc_pkg::SEQ_OFS + 8'h08, 32'h1);
		wr(bsc_pkg::VOUT_OFS + 8'h08, 32'hFF);
		SEQ_EN <= 3'h4;
		cyc(2);
		`CHK("seq en", 3'h6, BUCK_EN)
		cyc(4500);
		`CHK("clamp3", 22'(bsc_pkg::B3_BASE_UV + 254 * bsc_pkg::B3_STEP_UV), REF3)
		for (int m = 0; m < 4; m++)
			for (int s = 0; s < 2; s++) begin
				wr(bsc_pkg::PMODE_OFS, 32'(m << 4));
				SLP <= s[0];
				cyc(2);
				`CHK("lp", m >= 2 || (m == 1 && s == 1), BUCK_LOW_POWER[2])
			end
		$display("test seq and mode done");
		wr(bsc_pkg::VOUT_OFS, 32'h64);
		wr(bsc_pkg::CTRL_OFS, 32'h43);
		cyc(1550);
		`CHK("ref1", 22'(bsc_pkg::B1_BASE_UV + 100 * bsc_pkg::B1_STEP_UV), REF1)
		wr(bsc_pkg::VOUT_OFS, 32'h0);
		cyc(100);
		OV_CMP[0] <= 1'b1;
		rd(bsc_pkg::FLAG_OFS);
		`CHK("ov ramp", 32'h0, d)
		cyc(1200);
		`CHK("ov after", 2, pd)
		OV_CMP[0] <= 1'b0;
		wr(bsc_pkg::CTRL_OFS, 32'h3);
		wr(bsc_pkg::VOUT_OFS, 32'h64);
		cyc(1250);
		wr(bsc_pkg::VOUT_OFS, 32'h0);
		cyc(3);
		`CHK("jump1", 22'(bsc_pkg::B1_BASE_UV), REF1)
		OV_CMP[0] <= 1'b1;
		cyc(8);
		`CHK("ov jump pd", 3, pd)
		OV_CMP[0] <= 1'b0;
		$display("test buck1 done");
		conclude();
	end
endmodule
`default_nettype wire
